// ==== rxcmd_status_consts.svh ====
/*
 * offsets, field positions, reset values and codes of the status encoder.
 * assumes inclusion by the package and the encoder module only.
 */
`ifndef RXCMD_STATUS_CONSTS_SVH
`define RXCMD_STATUS_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFF_CTRL 12'h000
`define OFF_RISE 12'h004
`define OFF_FALL 12'h008
`define OFF_STAT 12'h00C

// ----------------------------------------------------------------
// control register fields and reset values
// ----------------------------------------------------------------
`define CTRL_PLUS_PD 0
`define CTRL_MINUS_PD 1
`define CTRL_XCVR_LO 2
`define CTRL_TERM 4
`define CTRL_OPMODE_LO 5
`define CTRL_POL_INV 7
`define CTRL_USE_EXT 8
`define CTRL_BYPASS 9
`define CTRL_RESET 10'h014
`define IEN_RESET 4'hF

// ----------------------------------------------------------------
// mode and field codes
// ----------------------------------------------------------------
`define XCVR_HS 2'h0
`define XCVR_LS 2'h2
`define OPMODE_CHIRP 2'h2
`define LS_SE0 2'h0
`define LS_NSQ_HI 2'h1
`define LS_NSQ_LO 2'h2
`define RXEV_IDLE 2'h0
`define RXEV_DISC 2'h2

`endif

// ==== rxcmd_status_encoder.sv ====
/*
 * status byte encoder of the phy: line state, supply state, receive events,
 * sent to the link on every line, event and id change and every enabled supply or disconnect edge, plus an apb register file.
 * assumes receiver and comparator levels on ref_clk or asynchronous pins,
 * and a link that accepts a status byte in any cycle.
 */
//
// Summary of operation
// - peripheral: fs line state is SE0/J/K/SE1, hs is squelch or not-squelch.
// - host: low speed 01 is K, 10 is J; host chirp uses receiver polarity.
// - peripheral chirp: 00 squelch, 01/10 not-squelch with receiver high/low.
// - session end and session valid come straight from the comparators.
// - supply field: 00 below end, 01 between, 10 session valid, 11 a-valid.
// - supply field change sends a status byte when its edge enable is set.
// - a-valid comes from selectable sources: comparator and/or fault input.
// - receive event: 00 idle, 01 active, 11 active error, 10 disconnect.
// - receive active shown by dir with nxt or a status byte, whole packet.
// - receive error drops nxt and sends a status byte with error code, or with 10 while disconnect is reported.
// - disconnect is reported only with both line pulldowns enabled.
// - disconnect change sends a status byte with the new value when its edge enable is set.
// - byte: line state 1:0, supply 3:2, event 5:4, id 6, bit 7 held at 0.
// - a status byte is delivered with dir high on the data bus.
// - any line state change sends a status byte with the new line state.
// - enabled fault input drives a-valid and each change sends a byte.

// ----------------------------------------------------------------
// three-stage synchroniser, change taken when stages two and three agree
// ----------------------------------------------------------------
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] level_r;
    logic [WIDTH-1:0] level_nxt;

    always_comb begin
        level_nxt = level_r;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                level_nxt[i] = s3_r[i];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            level_r <= '0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level_r <= level_nxt;
        end
    end

    assign level_out = level_r;
endmodule // pin_sync

`include "rxcmd_status_consts.svh"

module rxcmd_status_encoder #(
    parameter int DATA_W = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // analog and pin levels
    input wire logic dp_level,
    input wire logic dm_level,
    input wire logic squelch,
    input wire logic hs_diff_out,
    input wire logic session_end_flag,
    input wire logic session_valid_flag,
    input wire logic a_device_supply_valid_flag,
    input wire logic fault_pin,
    input wire logic id_pin,
    // receiver on ref_clk
    input wire logic rx_active,
    input wire logic rx_error,
    input wire logic host_disconnect,
    input wire logic rx_byte_valid,
    input wire logic [DATA_W-1:0] rx_byte,
    // ulpi side
    output logic dir,
    output logic nxt,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe_n
);
    generate
        if (DATA_W != 8) begin : g_width_check
            $error("rxcmd_status_encoder serves an eight-bit data bus only");
        end
    endgenerate

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [8:0] pins_s;
    logic dp_s, dm_s, sq_s, hsd_s, se_s, sv_s, av_s, fault_s, id_s;

    pin_sync #(.WIDTH(9)) u_pin_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin_in({id_pin, fault_pin, a_device_supply_valid_flag, session_valid_flag,
                 session_end_flag, hs_diff_out, squelch, dm_level, dp_level}),
        .level_out(pins_s)
    );
    assign {id_s, fault_s, av_s, sv_s, se_s, hsd_s, sq_s, dm_s, dp_s} = pins_s;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [9:0] ctrl_r, ctrl_nxt;
    logic [3:0] rise_en_r, rise_en_nxt;
    logic [3:0] fall_en_r, fall_en_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic mapped;
    logic [31:0] stat_word;

    logic plus_line_pulldown_enable, minus_line_pulldown_enable;
    logic [1:0] xcvr_select, op_mode;
    logic term_select, fault_polarity_invert, use_external_fault_indicator;
    logic fault_qualifier_bypass, host_mode;
    logic disconnect_rise_enable, disconnect_fall_enable;

    assign plus_line_pulldown_enable = ctrl_r[`CTRL_PLUS_PD];
    assign minus_line_pulldown_enable = ctrl_r[`CTRL_MINUS_PD];
    assign xcvr_select = ctrl_r[`CTRL_XCVR_LO +: 2];
    assign term_select = ctrl_r[`CTRL_TERM];
    assign op_mode = ctrl_r[`CTRL_OPMODE_LO +: 2];
    assign fault_polarity_invert = ctrl_r[`CTRL_POL_INV];
    assign use_external_fault_indicator = ctrl_r[`CTRL_USE_EXT];
    assign fault_qualifier_bypass = ctrl_r[`CTRL_BYPASS];
    assign host_mode = plus_line_pulldown_enable & minus_line_pulldown_enable;
    assign disconnect_rise_enable = rise_en_r[3];
    assign disconnect_fall_enable = fall_en_r[3];

    assign mapped = (paddr == `OFF_CTRL) || (paddr == `OFF_RISE) ||
                    (paddr == `OFF_FALL) || (paddr == `OFF_STAT);

    always_comb begin
        ctrl_nxt = ctrl_r;
        rise_en_nxt = rise_en_r;
        fall_en_nxt = fall_en_r;
        prdata_nxt = prdata_r;
        if (psel && penable && pwrite) begin
            case (paddr)
                `OFF_CTRL: ctrl_nxt = pwdata[9:0];
                `OFF_RISE: rise_en_nxt = pwdata[3:0];
                `OFF_FALL: fall_en_nxt = pwdata[3:0];
                default: ctrl_nxt = ctrl_r;
            endcase
        end
        if (psel && !penable) begin
            case (paddr)
                `OFF_CTRL: prdata_nxt = {22'h000000, ctrl_r};
                `OFF_RISE: prdata_nxt = {28'h0000000, rise_en_r};
                `OFF_FALL: prdata_nxt = {28'h0000000, fall_en_r};
                `OFF_STAT: prdata_nxt = stat_word;
                default: prdata_nxt = 32'h00000000;
            endcase
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = prdata_r;

    // ----------------------------------------------------------------
    // field encoders
    // ----------------------------------------------------------------
    logic [1:0] ls_now, vbus_now, rxev_now;
    logic a_valid, fault_ok, disc_valid;
    logic [7:0] status_now;

    always_comb begin
        ls_now = {dm_s, dp_s};
        if (xcvr_select == `XCVR_HS) begin
            if ((!host_mode && term_select) || (host_mode && op_mode == `OPMODE_CHIRP)) begin
                ls_now = sq_s ? `LS_SE0 : (hsd_s ? `LS_NSQ_HI : `LS_NSQ_LO);
            end else begin
                ls_now = sq_s ? `LS_SE0 : `LS_NSQ_HI;
            end
        end
    end

    assign fault_ok = fault_polarity_invert ? fault_s : ~fault_s;
    always_comb begin
        a_valid = av_s;
        if (use_external_fault_indicator) begin
            a_valid = fault_qualifier_bypass ? fault_ok : (fault_ok & av_s);
        end
    end

    assign vbus_now = a_valid ? 2'h3 : (sv_s ? 2'h2 : (se_s ? 2'h0 : 2'h1));
    assign disc_valid = host_mode & host_disconnect;
    assign rxev_now = disc_valid ? `RXEV_DISC : {rx_active & rx_error, rx_active};
    assign status_now = {1'b0, id_s, rxev_now, vbus_now, ls_now};

    // ----------------------------------------------------------------
    // change detection
    // ----------------------------------------------------------------
    logic [1:0] ls_prev_r, ls_prev_nxt;
    logic [2:0] vb_prev_r, vb_prev_nxt;
    logic [1:0] ev_prev_r, ev_prev_nxt;
    logic disc_prev_r, disc_prev_nxt;
    logic id_prev_r, id_prev_nxt;
    logic fault_prev_r, fault_prev_nxt;
    logic [2:0] vb_flags, vb_rise, vb_fall;
    logic disc_chg, trigger;

    assign vb_flags = {a_valid, sv_s, se_s};
    assign vb_rise = vb_flags & ~vb_prev_r;
    assign vb_fall = ~vb_flags & vb_prev_r;
    assign disc_chg = (disc_valid & ~disc_prev_r & disconnect_rise_enable) |
                      (~disc_valid & disc_prev_r & disconnect_fall_enable);

    always_comb begin
        ls_prev_nxt = ls_now;
        vb_prev_nxt = vb_flags;
        ev_prev_nxt = {rx_active & rx_error, rx_active};
        disc_prev_nxt = disc_valid;
        id_prev_nxt = id_s;
        fault_prev_nxt = fault_s;
        trigger = (ls_now != ls_prev_r)
                | (|((vb_rise & rise_en_r[2:0]) | (vb_fall & fall_en_r[2:0])))
                | (ev_prev_nxt != ev_prev_r)
                | disc_chg
                | (id_s != id_prev_r)
                | (use_external_fault_indicator && fault_s != fault_prev_r);
    end

    // ----------------------------------------------------------------
    // data bus driver
    // ----------------------------------------------------------------
    rxcmd_status_pkg::slot_t slot;
    logic pending_r, pending_nxt;
    logic dir_r, dir_nxt, nxt_r, nxt_nxt;
    logic [7:0] data_out_r, data_out_nxt;

    assign stat_word = {15'h0000, pending_r, data_out_r, status_now};

    always_comb begin
        slot = rxcmd_status_pkg::SLOT_IDLE;
        if (rx_active && rx_byte_valid && !rx_error) begin
            slot = rxcmd_status_pkg::SLOT_DATA;
        end else if (pending_r || trigger || rx_active) begin
            slot = rxcmd_status_pkg::SLOT_STATUS;
        end
    end

    always_comb begin
        dir_nxt = 1'b0;
        nxt_nxt = 1'b0;
        data_out_nxt = 8'h00;
        pending_nxt = pending_r | trigger;
        case (slot)
            rxcmd_status_pkg::SLOT_DATA: begin
                dir_nxt = 1'b1;
                nxt_nxt = 1'b1;
                data_out_nxt = rx_byte;
            end
            rxcmd_status_pkg::SLOT_STATUS: begin
                dir_nxt = 1'b1;
                data_out_nxt = status_now;
                pending_nxt = 1'b0;
            end
            default: begin
                dir_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_r <= `CTRL_RESET;
            rise_en_r <= `IEN_RESET;
            fall_en_r <= `IEN_RESET;
            prdata_r <= 32'h00000000;
            ls_prev_r <= 2'h0;
            vb_prev_r <= 3'h0;
            ev_prev_r <= 2'h0;
            disc_prev_r <= 1'b0;
            id_prev_r <= 1'b0;
            fault_prev_r <= 1'b0;
            pending_r <= 1'b0;
            dir_r <= 1'b0;
            nxt_r <= 1'b0;
            data_out_r <= 8'h00;
        end else begin
            ctrl_r <= ctrl_nxt;
            rise_en_r <= rise_en_nxt;
            fall_en_r <= fall_en_nxt;
            prdata_r <= prdata_nxt;
            ls_prev_r <= ls_prev_nxt;
            vb_prev_r <= vb_prev_nxt;
            ev_prev_r <= ev_prev_nxt;
            disc_prev_r <= disc_prev_nxt;
            id_prev_r <= id_prev_nxt;
            fault_prev_r <= fault_prev_nxt;
            pending_r <= pending_nxt;
            dir_r <= dir_nxt;
            nxt_r <= nxt_nxt;
            data_out_r <= data_out_nxt;
        end
    end

    assign dir = dir_r;
    assign nxt = nxt_r;
    assign data_out = data_out_r;
    assign data_oe_n = ~dir_r;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_fs_line_code: assert property (
        (!host_mode && xcvr_select != `XCVR_HS) |-> ls_now == {dm_s, dp_s})
        else $error("full speed line state not raw line levels");
    a_host_ls_k: assert property (
        (host_mode && xcvr_select == `XCVR_LS && dp_s && !dm_s) |-> ls_now == 2'h1)
        else $error("low speed K not reported as 01");
    a_chirp_code: assert property (
        (!host_mode && xcvr_select == `XCVR_HS && term_select && !sq_s && !hsd_s) |-> ls_now == 2'h2)
        else $error("chirp with receiver low not 10");
    a_supply_top: assert property (
        (a_valid |-> vbus_now == 2'h3) and ((!a_valid && !sv_s && se_s) |-> vbus_now == 2'h0))
        else $error("supply field encoding wrong");
    a_disc_host_only: assert property (
        (rxev_now == `RXEV_DISC) |-> (host_mode && host_disconnect))
        else $error("disconnect reported outside host mode");
    a_line_change_sent: assert property (
        (ls_now != ls_prev_r && slot != rxcmd_status_pkg::SLOT_DATA)
        |=> dir_r && !nxt_r && data_out_r == $past(status_now))
        else $error("line change not sent next cycle");
    a_error_drops_nxt: assert property (
        (rx_active && rx_error) |=> !nxt_r ##1 (!nxt_r || !$past(rx_error)))
        else $error("nxt high after receive error");
    a_rx_dir_held: assert property (
        rx_active |=> dir_r)
        else $error("dir low during receive");
    a_pending_served: assert property (
        (pending_r && !rx_active) |=> dir_r && !nxt_r && !pending_r)
        else $error("pending status byte not delivered");

    c_data_byte: cover property (rx_active && rx_byte_valid ##1 nxt_r);
    c_status_byte: cover property (trigger ##1 (dir_r && !nxt_r));
    c_disconnect: cover property (disc_valid ##1 data_out_r[5:4] == `RXEV_DISC);
endmodule // rxcmd_status_encoder

// ==== rxcmd_status_encoder_tb_top.sv ====
/*
 * self-checking bench of the status encoder: apb master, pin stimulus, expected-byte queue.
 * assumes the encoder with DATA_W 8 and the link model beside it.
 */
module rxcmd_status_encoder_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, rerr, dir, nxt, data_oe_n, ev_stb, rx_seen, pkt_dropped;
    logic dp_level = 1'b0, dm_level = 1'b0, squelch = 1'b0, hs_diff_out = 1'b0, fault_pin = 1'b0;
    logic session_end_flag = 1'b1, session_valid_flag = 1'b0, a_device_supply_valid_flag = 1'b0;
    logic id_pin = 1'b0, rx_active = 1'b0, rx_error = 1'b0, host_disconnect = 1'b0, rx_byte_valid = 1'b0;
    logic [7:0] rx_byte = 8'h00, data_out, last_exp = 8'h00;
    logic [8:0] ev_word;
    logic [8:0] exp_q[$];
    logic [9:0] ctrl_sh = 10'h014;
    logic [9:0] modes [6] = '{10'h000, 10'h010, 10'h01B, 10'h017, 10'h003, 10'h043};
    logic [17:0] sup_seq = 18'h027F4;
    int miscompares = 0, num_checks = 0;

    always #50 ref_clk = ~ref_clk;

    rxcmd_status_encoder #(.DATA_W(8)) u_rxcmd_status_encoder (.ref_clk(ref_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dp_level(dp_level), .dm_level(dm_level), .squelch(squelch),
        .hs_diff_out(hs_diff_out), .session_end_flag(session_end_flag), .session_valid_flag(session_valid_flag),
        .a_device_supply_valid_flag(a_device_supply_valid_flag), .fault_pin(fault_pin), .id_pin(id_pin),
        .rx_active(rx_active), .rx_error(rx_error), .host_disconnect(host_disconnect),
        .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .dir(dir), .nxt(nxt), .data_out(data_out),
        .data_oe_n(data_oe_n));

    ulpi_link_model u_ulpi_link_model (.ref_clk(ref_clk), .rst(rst), .dir(dir), .nxt(nxt), .data_out(data_out),
        .data_oe_n(data_oe_n), .ev_stb(ev_stb), .ev_word(ev_word), .rx_seen(rx_seen), .pkt_dropped(pkt_dropped));

    // ----------------------------------------------------------------
    // expected status byte and helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] calc();
        logic host, fok, av;
        logic [1:0] ls, sup, ev;
        host = ctrl_sh[0] & ctrl_sh[1];
        if (ctrl_sh[3:2] != 2'h0) ls = {dm_level, dp_level};
        else if (squelch) ls = 2'h0;
        else if (host ? ctrl_sh[6:5] == 2'h2 : ctrl_sh[4]) ls = hs_diff_out ? 2'h1 : 2'h2;
        else ls = 2'h1;
        fok = ctrl_sh[7] ? fault_pin : ~fault_pin;
        av = !ctrl_sh[8] ? a_device_supply_valid_flag : (ctrl_sh[9] ? fok : fok & a_device_supply_valid_flag);
        sup = av ? 2'h3 : session_valid_flag ? 2'h2 : session_end_flag ? 2'h0 : 2'h1;
        ev = (host && host_disconnect) ? 2'h2 : !rx_active ? 2'h0 : rx_error ? 2'h3 : 2'h1;
        return {1'b0, id_pin, ev, sup, ls};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        if (a == 12'h000) ctrl_sh = d[9:0];
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic err);
        apb(1'b0, a, 32'h0);
        check(rdat, exp);
        check({31'h0, rerr}, {31'h0, err});
    endtask

    task automatic step(input bit send);
        logic [7:0] e;
        @(posedge ref_clk);
        e = calc();
        if (send && e !== last_exp) begin
            exp_q.push_back({1'b0, e});
            last_exp = e;
        end
        repeat (10) @(posedge ref_clk);
    endtask

    task automatic rx_data(input logic err);
        logic [7:0] b;
        b = 8'($urandom);
        rx_byte <= b;
        rx_byte_valid <= 1'b1;
        rx_error <= err;
        @(posedge ref_clk);
        rx_byte_valid <= 1'b0;
        if (!err) exp_q.push_back({1'b1, b});
        step(1'b1);
    endtask

    task automatic end_sim();
        if (exp_q.size() != 0) miscompares++;
        if (miscompares == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // result watcher and watchdog
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (ev_stb === 1'b1) begin
            if (exp_q.size() == 0) check({23'h0, ev_word}, 32'hFFFFFFFF);
            else check({23'h0, ev_word}, {23'h0, exp_q.pop_front()});
        end
    end

    initial begin
        repeat (5000) @(posedge ref_clk);
        miscompares++;
        end_sim();
    end

    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'hDF010097));
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        rd_chk(12'h000, 32'h14, 1'b0);
        rd_chk(12'h004, 32'hF, 1'b0);
        rd_chk(12'h008, 32'hF, 1'b0);
        rd_chk(12'h010, 32'h0, 1'b1);
        wr_reg(12'h004, 32'hF);
        wr_reg(12'h008, 32'hF);
        for (int i = 0; i < 8; i++) begin
            {dm_level, dp_level} <= 2'(i < 4 ? i + 1 : $urandom);
            step(1'b1);
        end
        for (int m = 0; m < 6; m++) begin
            wr_reg(12'h000, {22'h0, modes[m]});
            step(1'b1);
            for (int j = 0; j < 4; j++) begin
                {squelch, hs_diff_out} <= 2'(j);
                {dm_level, dp_level} <= 2'(j + 1);
                step(1'b1);
            end
        end
        host_disconnect <= 1'b1;
        step(1'b1);
        rx_active <= 1'b1;
        step(1'b1);
        rx_active <= 1'b0;
        host_disconnect <= 1'b0;
        step(1'b1);
        wr_reg(12'h000, 32'h014);
        step(1'b1);
        host_disconnect <= 1'b1;
        step(1'b1);
        host_disconnect <= 1'b0;
        step(1'b1);
        for (int k = 0; k < 6; k++) begin
            {session_end_flag, session_valid_flag, a_device_supply_valid_flag} <= sup_seq[17 - 3 * k -: 3];
            step(1'b1);
        end
        wr_reg(12'h004, 32'h0);
        wr_reg(12'h008, 32'h0);
        session_valid_flag <= 1'b1;
        step(1'b0);
        session_valid_flag <= 1'b0;
        step(1'b0);
        wr_reg(12'h004, 32'hF);
        wr_reg(12'h008, 32'hF);
        wr_reg(12'h000, 32'h314);
        step(1'b1);
        rd_chk(12'h000, 32'h314, 1'b0);
        fault_pin <= 1'b1;
        step(1'b1);
        wr_reg(12'h000, 32'h394);
        step(1'b1);
        wr_reg(12'h000, 32'h194);
        step(1'b1);
        a_device_supply_valid_flag <= 1'b1;
        step(1'b1);
        fault_pin <= 1'b0;
        step(1'b1);
        wr_reg(12'h000, 32'h014);
        step(1'b1);
        a_device_supply_valid_flag <= 1'b0;
        step(1'b1);
        rx_active <= 1'b1;
        step(1'b1);
        check({31'h0, rx_seen}, 32'h1);
        rx_data(1'b0);
        rx_data(1'b0);
        rx_data(1'b1);
        check({31'h0, pkt_dropped}, 32'h1);
        rx_error <= 1'b0;
        rx_active <= 1'b0;
        step(1'b1);
        check({31'h0, rx_seen}, 32'h0);
        {id_pin, dp_level, dm_level} <= 3'h6;
        step(1'b1);
        apb(1'b0, 12'h00C, 32'h0);
        check({24'h0, rdat[7:0]}, {24'h0, last_exp});
        end_sim();
    end
endmodule // rxcmd_status_encoder_tb_top

// ==== rxcmd_status_pkg.sv ====
/*
 * types of the status encoder.
 * assumes rxcmd_status_consts.svh in the include path.
 */
package rxcmd_status_pkg;
    // ----------------------------------------------------------------
    // bus slot owner of the data bus
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SLOT_IDLE,
        SLOT_DATA,
        SLOT_STATUS
    } slot_t;
endpackage

// ==== ulpi_link_model.sv ====
/*
 * link-side model: watches the ulpi bus, reports each new status byte and each data byte.
 * assumes a phy that owns the bus while dir is high and drives data_out with data_oe_n low.
 */
module ulpi_link_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic dir,
    input wire logic nxt,
    input wire logic [7:0] data_out,
    input wire logic data_oe_n,
    output logic ev_stb,
    output logic [8:0] ev_word,
    output logic rx_seen,
    output logic pkt_dropped
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] last_status;
    logic [7:0] pkt_cnt;

    // ----------------------------------------------------------------
    // bus watcher
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        ev_stb <= 1'b0;
        if (rst) begin
            last_status <= 8'h00;
            ev_word <= 9'h000;
            rx_seen <= 1'b0;
            pkt_dropped <= 1'b0;
            pkt_cnt <= 8'h00;
        end else if (dir && !data_oe_n) begin
            if (nxt) begin
                ev_stb <= 1'b1;
                ev_word <= {1'b1, data_out};
                rx_seen <= 1'b1;
                pkt_cnt <= pkt_cnt + 8'h01;
            end else begin
                rx_seen <= data_out[4];
                if (data_out[5:4] == 2'h3) begin
                    pkt_dropped <= 1'b1;
                    pkt_cnt <= 8'h00;
                end
                if (data_out != last_status) begin
                    ev_stb <= 1'b1;
                    ev_word <= {1'b0, data_out};
                end
                last_status <= data_out;
            end
        end else begin
            rx_seen <= 1'b0;
        end
    end
endmodule // ulpi_link_model
